// [core/bst_pkg.sv]
// Constants, opcodes and controller states shared by the boundary-scan port design.
package bst_pkg;

  // ----------------------------------------------------------------------------
  // Register lengths
  // ----------------------------------------------------------------------------
  localparam int unsigned IR_LEN      = 3;
  localparam int unsigned BSR_LEN_S   = 273;
  localparam int unsigned BSR_LEN_M   = 417;
  localparam int unsigned BSR_LEN_L   = 465;
  localparam int unsigned BSR_LEN_XL  = 645;
  localparam int unsigned BUF_WIDTH   = 1;

  // ----------------------------------------------------------------------------
  // Instruction opcodes and reset values
  // ----------------------------------------------------------------------------
  localparam logic [IR_LEN-1:0] OP_EXTEST   = 3'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE   = 3'h5;
  localparam logic [IR_LEN-1:0] OP_BYPASS   = 3'h7;
  localparam logic [IR_LEN-1:0] IR_CAPTURE  = 3'h1;
  localparam logic              BYP_CAPTURE = 1'h0;
  localparam logic              PIN_IDLE    = 1'h1;

  // ----------------------------------------------------------------------------
  // Test access port controller states
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } bst_state_e;

endpackage : bst_pkg

// [core/bst_buf2.sv]
// Two-entry valid/ready buffer for the serial output bits.
`timescale 1ns/100ps
`default_nettype none

module bst_buf2 #(
  parameter int unsigned WIDTH = bst_pkg::BUF_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_reg [2];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= 1'h0;
      rd_ptr_reg <= 1'h0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'h0, push} - {1'h0, pop};
    end
  end

endmodule : bst_buf2

`default_nettype wire

// [core/bst_bsr.sv]
// Boundary-scan register: capture, shift and update stages for every pin cell.
`timescale 1ns/100ps
`default_nettype none

module bst_bsr #(
  parameter int unsigned LEN = bst_pkg::BSR_LEN_S
) (
  input  wire logic           clock,
  input  wire logic           nrst,
  input  wire logic           capture_en,
  input  wire logic           shift_en,
  input  wire logic           update_en,
  input  wire logic           scan_in,
  input  wire logic           drive_test,
  input  wire logic [LEN-1:0] pin_in,
  input  wire logic [LEN-1:0] core_out,
  output logic                scan_out,
  output logic      [LEN-1:0] pin_out
);

  logic [LEN-1:0] cap_reg;
  logic [LEN-1:0] upd_reg;

  assign scan_out = cap_reg[0];

  genvar i;
  generate
    for (i = 0; i < LEN; i++) begin : g_cell
      logic shift_src;
      if (i == LEN - 1) begin : g_top
        assign shift_src = scan_in;
      end else begin : g_mid
        assign shift_src = cap_reg[i+1];
      end

      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          cap_reg[i] <= 1'h0;
        end else if (capture_en) begin
          cap_reg[i] <= pin_in[i];
        end else if (shift_en) begin
          cap_reg[i] <= shift_src;
        end
      end

      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          upd_reg[i] <= 1'h0;
        end else if (update_en) begin
          upd_reg[i] <= cap_reg[i];
        end
      end

      // Core logic keeps the pin unless a pin-driving instruction is in force.
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          pin_out[i] <= 1'h0;
        end else begin
          pin_out[i] <= drive_test ? upd_reg[i] : core_out[i];
        end
      end
    end
  endgenerate

endmodule : bst_bsr

`default_nettype wire

// [core/bst_tap.sv]
// Boundary-scan test access port: controller, instruction, bypass and output path.
`timescale 1ns/100ps
`default_nettype none

module bst_tap #(
  parameter int unsigned BSR_LEN = bst_pkg::BSR_LEN_S
) (
  input  wire logic               clock,
  input  wire logic               nrst,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  input  wire logic [BSR_LEN-1:0] pin_in,
  input  wire logic [BSR_LEN-1:0] core_out,
  output logic      [BSR_LEN-1:0] pin_out,
  output logic      [2:0]         instr,
  output logic                    in_reset
);

  // ----------------------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------------------
  function automatic logic sel_bsr(input logic [bst_pkg::IR_LEN-1:0] op);
    sel_bsr = (op == bst_pkg::OP_EXTEST) || (op == bst_pkg::OP_SAMPLE);
  endfunction : sel_bsr

  function automatic logic is_shift(input bst_pkg::bst_state_e st);
    is_shift = (st == bst_pkg::ST_SHIFT_DR) || (st == bst_pkg::ST_SHIFT_IR);
  endfunction : is_shift

  logic                        tck_s1_reg;
  logic                        tck_s2_reg;
  logic                        tck_s3_reg;
  logic                        tms_s1_reg;
  logic                        tms_s2_reg;
  logic                        tdi_s1_reg;
  logic                        tdi_s2_reg;
  logic                        tck_rise;
  logic                        tck_fall;
  logic                        rise_pend_reg;
  logic                        rise_act;
  logic                        tms_hold_reg;
  logic                        tdi_hold_reg;
  logic                        tms_use;
  logic                        tdi_use;
  bst_pkg::bst_state_e         state_reg;
  bst_pkg::bst_state_e         state_next;
  logic [bst_pkg::IR_LEN-1:0]  ir_sh_reg;
  logic [bst_pkg::IR_LEN-1:0]  instr_reg;
  logic                        byp_reg;
  logic                        bsr_out;
  logic                        bsr_cap;
  logic                        bsr_shift;
  logic                        bsr_upd;
  logic                        ser_bit;
  logic                        buf_in_valid;
  logic                        buf_in_ready;
  logic                        buf_out_valid;
  logic [0:0]                  buf_out_data;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  // The tms and tdi flops reset high so that a floating test input behaves as if pulled up.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tms_s1_reg <= bst_pkg::PIN_IDLE;
      tms_s2_reg <= bst_pkg::PIN_IDLE;
      tdi_s1_reg <= bst_pkg::PIN_IDLE;
      tdi_s2_reg <= bst_pkg::PIN_IDLE;
    end else begin
      tms_s1_reg <= tms;
      tms_s2_reg <= tms_s1_reg;
      tdi_s1_reg <= tdi;
      tdi_s2_reg <= tdi_s1_reg;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tck_s1_reg <= 1'h0;
      tck_s2_reg <= 1'h0;
      tck_s3_reg <= 1'h0;
    end else begin
      tck_s1_reg <= tck;
      tck_s2_reg <= tck_s1_reg;
      tck_s3_reg <= tck_s2_reg;
    end
  end

  // Test clock and data share the same synchroniser depth, so the data seen with
  // a detected edge is the data that stood at the pins when that edge arrived.
  assign tck_rise = tck_s2_reg & ~tck_s3_reg;
  assign tck_fall = ~tck_s2_reg & tck_s3_reg;

  // ----------------------------------------------------------------------------
  // Rising-edge scheduling
  // ----------------------------------------------------------------------------
  // A rising edge that meets a full output buffer is held pending rather than
  // lost; the buffer drains every cycle, so the wait is at most one cycle.
  assign rise_act = (tck_rise | rise_pend_reg) & buf_in_ready;
  assign tms_use  = rise_pend_reg ? tms_hold_reg : tms_s2_reg;
  assign tdi_use  = rise_pend_reg ? tdi_hold_reg : tdi_s2_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rise_pend_reg <= 1'h0;
      tms_hold_reg  <= bst_pkg::PIN_IDLE;
      tdi_hold_reg  <= bst_pkg::PIN_IDLE;
    end else if (tck_rise && !buf_in_ready) begin
      rise_pend_reg <= 1'h1;
      tms_hold_reg  <= tms_s2_reg;
      tdi_hold_reg  <= tdi_s2_reg;
    end else if (rise_act) begin
      rise_pend_reg <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bst_pkg::ST_RESET:    state_next = tms_use ? bst_pkg::ST_RESET   : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE:     state_next = tms_use ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR:   state_next = tms_use ? bst_pkg::ST_SEL_IR  : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR:   state_next = tms_use ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_SHIFT_DR: state_next = tms_use ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_EXIT1_DR: state_next = tms_use ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_PAUSE_DR: state_next = tms_use ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_EXIT2_DR: state_next = tms_use ? bst_pkg::ST_UPD_DR  : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_UPD_DR:   state_next = tms_use ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR:   state_next = tms_use ? bst_pkg::ST_RESET   : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR:   state_next = tms_use ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_SHIFT_IR: state_next = tms_use ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_EXIT1_IR: state_next = tms_use ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_PAUSE_IR: state_next = tms_use ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_EXIT2_IR: state_next = tms_use ? bst_pkg::ST_UPD_IR  : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_UPD_IR:   state_next = tms_use ? bst_pkg::ST_SEL_DR  : bst_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= bst_pkg::ST_RESET;
    end else if (rise_act) begin
      state_reg <= state_next;
    end
  end

  assign in_reset = (state_reg == bst_pkg::ST_RESET);

  // ----------------------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ir_sh_reg <= bst_pkg::IR_CAPTURE;
    end else if (rise_act) begin
      if (state_reg == bst_pkg::ST_CAP_IR) begin
        ir_sh_reg <= bst_pkg::IR_CAPTURE;
      end else if (state_reg == bst_pkg::ST_SHIFT_IR) begin
        ir_sh_reg <= {tdi_use, ir_sh_reg[bst_pkg::IR_LEN-1:1]};
      end
    end
  end

  // The instruction loads on the falling edge of update, as the pins expect; test-logic-reset forces bypass.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      instr_reg <= bst_pkg::OP_BYPASS;
    end else if (state_reg == bst_pkg::ST_RESET) begin
      instr_reg <= bst_pkg::OP_BYPASS;
    end else if (tck_fall && state_reg == bst_pkg::ST_UPD_IR) begin
      instr_reg <= ir_sh_reg;
    end
  end

  assign instr = instr_reg;

  // ----------------------------------------------------------------------------
  // Bypass register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      byp_reg <= bst_pkg::BYP_CAPTURE;
    end else if (rise_act && !sel_bsr(instr_reg)) begin
      if (state_reg == bst_pkg::ST_CAP_DR) begin
        byp_reg <= bst_pkg::BYP_CAPTURE;
      end else if (state_reg == bst_pkg::ST_SHIFT_DR) begin
        byp_reg <= tdi_use;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Boundary-scan register
  // ----------------------------------------------------------------------------
  assign bsr_cap   = rise_act && sel_bsr(instr_reg) && (state_reg == bst_pkg::ST_CAP_DR);
  assign bsr_shift = rise_act && sel_bsr(instr_reg) && (state_reg == bst_pkg::ST_SHIFT_DR);
  assign bsr_upd   = tck_fall && sel_bsr(instr_reg) && (state_reg == bst_pkg::ST_UPD_DR);

  bst_bsr #(
    .LEN (BSR_LEN)
  ) u_bsr (
    .clock      (clock),
    .nrst       (nrst),
    .capture_en (bsr_cap),
    .shift_en   (bsr_shift),
    .update_en  (bsr_upd),
    .scan_in    (tdi_use),
    .drive_test (instr_reg == bst_pkg::OP_EXTEST),
    .pin_in     (pin_in),
    .core_out   (core_out),
    .scan_out   (bsr_out),
    .pin_out    (pin_out)
  );

  // ----------------------------------------------------------------------------
  // Serial output path
  // ----------------------------------------------------------------------------
  always_comb begin
    if (state_reg == bst_pkg::ST_SHIFT_IR) begin
      ser_bit = ir_sh_reg[0];
    end else if (sel_bsr(instr_reg)) begin
      ser_bit = bsr_out;
    end else begin
      ser_bit = byp_reg;
    end
  end

  assign buf_in_valid = tck_fall && is_shift(state_reg);

  bst_buf2 #(
    .WIDTH (bst_pkg::BUF_WIDTH)
  ) u_buf (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (ser_bit),
    .out_valid (buf_out_valid),
    .out_ready (1'h1),
    .out_data  (buf_out_data)
  );

  // The output is released on a falling edge outside shifting, so it lets go of
  // the line in step with the point where it would otherwise have changed.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tdo    <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (buf_out_valid) begin
      tdo    <= buf_out_data[0];
      tdo_oe <= 1'h1;
    end else if (tck_fall && !is_shift(state_reg)) begin
      tdo_oe <= 1'h0;
    end
  end

endmodule : bst_tap

`default_nettype wire

// [sim/bst_tap_sva.sv]
// Concurrent checks on the boundary-scan port outputs, timed against the sampled test clock.
`timescale 1ns/100ps
`default_nettype none

module bst_tap_sva #(
  parameter int unsigned BSR_LEN = bst_pkg::BSR_LEN_S
) (
  input wire logic               clock,
  input wire logic               nrst,
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdi,
  input wire logic               tdo,
  input wire logic               tdo_oe,
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_out,
  input wire logic [BSR_LEN-1:0] pin_out,
  input wire logic [2:0]         instr,
  input wire logic               in_reset
);
  // ----------------------------------------------------------------------------
  // Test clock edge age
  // ----------------------------------------------------------------------------
  // Counters saturate, so a long quiet link can never look like a recent edge.
  logic       tck_q;
  logic [3:0] since_fall;
  logic [3:0] since_rise;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tck_q      <= 1'h0;
      since_fall <= 4'hF;
      since_rise <= 4'hF;
    end else begin
      tck_q      <= tck;
      since_fall <= (tck_q && !tck) ? 4'h0 : ((since_fall == 4'hF) ? 4'hF : since_fall + 4'h1);
      since_rise <= (!tck_q && tck) ? 4'h0 : ((since_rise == 4'hF) ? 4'hF : since_rise + 4'h1);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence fell_lately_s;
    since_fall <= 4'h8;
  endsequence

  sequence rose_lately_s;
    since_rise <= 4'h8;
  endsequence

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  reset_bypass_a: assert property (in_reset [*2] |-> instr == bst_pkg::OP_BYPASS)
    else $error("instruction not bypass in test logic reset");
  oe_reset_a: assert property (in_reset |-> !tdo_oe)
    else $error("tdo driven in test logic reset");
  oe_rise_a: assert property ($rose(tdo_oe) |-> fell_lately_s)
    else $error("tdo enable rose away from a falling test clock");
  oe_fall_a: assert property ($fell(tdo_oe) |-> fell_lately_s)
    else $error("tdo enable fell away from a falling test clock");
  tdo_move_a: assert property ($changed(tdo) |-> fell_lately_s)
    else $error("tdo changed away from a falling test clock");
  state_rise_a: assert property ($changed(in_reset) |-> rose_lately_s)
    else $error("controller moved away from a rising test clock");
  instr_move_a: assert property ($changed(instr) |-> fell_lately_s or rose_lately_s)
    else $error("instruction changed without a test clock edge");
  pin_follow_a: assert property ($past(nrst) && instr != bst_pkg::OP_EXTEST && $past(instr) != bst_pkg::OP_EXTEST
                                 |-> pin_out == $past(core_out))
    else $error("pins not following core outside extest");
  extest_hold_a: assert property (instr == bst_pkg::OP_EXTEST && $past(instr) == bst_pkg::OP_EXTEST
                                  && $changed(pin_out) |-> fell_lately_s)
    else $error("pins changed under extest without an update");
endmodule : bst_tap_sva

bind bst_tap bst_tap_sva #(.BSR_LEN(BSR_LEN)) chk (
  .clock(clock), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
  .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .instr(instr), .in_reset(in_reset)
);

`default_nettype wire

// [sim/bst_ctl_model.sv]
// Behavioural board test controller driving the four-wire test port.
`timescale 1ns/100ps
`default_nettype none

module bst_ctl_model (
  input  wire logic clock,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  localparam int HALF = 20;

  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // One test clock period; tck rests low between calls, so it only runs inside a frame.
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clock);
    tms <= m;
    tdi <= d;
    repeat (HALF - 1) @(posedge clock);
    q = tdo_oe ? tdo : 1'h1;
    tck <= 1'h1;
    repeat (HALF) @(posedge clock);
    tck <= 1'h0;
  endtask : step
endmodule : bst_ctl_model

`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam int unsigned N     = bst_pkg::BSR_LEN_S;
  localparam int          LIMIT = 50000;

  logic         clock    = 1'h0;
  logic         nrst     = 1'h0;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo;
  logic         tdo_oe;
  logic         in_reset;
  logic [2:0]   instr;
  logic [N-1:0] pin_in   = '0;
  logic [N-1:0] core_out = '0;
  logic [N-1:0] pin_out;
  int           err_total = 0;
  int           compares  = 0;
  int           cycles    = 0;

  always #2 clock = ~clock;

  bst_tap #(.BSR_LEN(N)) dut (
    .clock(clock), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .instr(instr), .in_reset(in_reset)
  );

  bst_ctl_model ctl (
    .clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe)
  );

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [N+7:0] seen, input logic [N+7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [N+7:0] pat(input int k);
    for (int i = 0; i < N + 8; i++) pat[i] = ((i * k) % 7) < 3;
  endfunction : pat

  task automatic walk(input logic [7:0] ms, input int n);
    logic q;
    for (int i = 0; i < n; i++) ctl.step(ms[i], 1'h0, q);
  endtask : walk

  // Starts and ends in run-test-idle.
  task automatic ir_load(input logic [2:0] op, output logic [2:0] cap);
    logic q;
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      ctl.step(i == 2, op[i], q);
      cap[i] = q;
    end
    walk(8'h01, 2);
  endtask : ir_load

  task automatic dr_scan(input int n, input logic [N+7:0] din, output logic [N+7:0] dout);
    logic q;
    dout = '0;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      ctl.step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    walk(8'h01, 2);
  endtask : dr_scan

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset;
    check("instr", instr, bst_pkg::OP_BYPASS);
    check("in_reset", in_reset, 1'h1);
    check("tdo_oe", tdo_oe, 1'h0);
    core_out <= N'(pat(11));
    repeat (2) @(posedge clock);
    check("pin_out", pin_out, core_out);
    // Later loads walk from run-test-idle, so leave test-logic-reset first.
    walk(8'h00, 1);
    check("in_reset", in_reset, 1'h0);
    $display("test reset done");
  endtask : t_reset

  // Every opcode: unknown ones must fall back to the one-bit path.
  task automatic t_ops;
    logic [2:0]   cap;
    logic [N+7:0] d;
    logic         byp;
    pin_in <= N'(pat(5));
    for (int op = 0; op < 8; op++) begin
      ir_load(op[2:0], cap);
      check("ir capture", cap, bst_pkg::IR_CAPTURE);
      if (op == 0 || op == 5 || op == 7) check("instr", instr, op[2:0]);
      dr_scan(2, 'h1, d);
      byp = !(op == 0 || op == 5);
      check("dr path", d, byp ? {1'h1, bst_pkg::BYP_CAPTURE} : {pin_in[1], pin_in[0]});
    end
    $display("test opcodes done");
  endtask : t_ops

  task automatic t_sample_extest;
    logic [2:0]   cap;
    logic [N+7:0] d;
    logic [N+7:0] q;
    pin_in <= N'(pat(3));
    core_out <= N'(pat(2));
    ir_load(bst_pkg::OP_SAMPLE, cap);
    d = pat(13);
    dr_scan(N + 8, d, q);
    check("sampled chain", q, {d[7:0], N'(pat(3))});
    check("pin_out", pin_out, core_out);
    ir_load(bst_pkg::OP_EXTEST, cap);
    check("preloaded pins", pin_out, d[N+7:8]);
    pin_in <= N'(pat(17));
    core_out <= N'(pat(19));
    d = pat(23);
    dr_scan(N, d, q);
    check("extest capture", q, N'(pat(17)));
    check("extest pins", pin_out, d[N-1:0]);
    $display("test sample and extest done");
  endtask : t_sample_extest

  task automatic t_bypass_reset;
    logic [2:0]   cap;
    logic [N+7:0] q;
    logic         b0;
    logic         b1;
    ir_load(bst_pkg::OP_BYPASS, cap);
    core_out <= N'(pat(29));
    dr_scan(9, 'h1B5, q);
    check("bypass stream", q, {8'hB5, bst_pkg::BYP_CAPTURE});
    // A scan broken by a pause must resume with the bit shifted in before it.
    walk(8'h01, 3);
    ctl.step(1'h1, 1'h1, b0);
    walk(8'h02, 3);
    ctl.step(1'h1, 1'h0, b1);
    walk(8'h01, 2);
    check("pause resume", {b1, b0}, 2'h2);
    check("pin_out", pin_out, core_out);
    ir_load(bst_pkg::OP_EXTEST, cap);
    walk(8'h1F, 5);
    check("in_reset", in_reset, 1'h1);
    check("instr", instr, bst_pkg::OP_BYPASS);
    check("pin_out", pin_out, core_out);
    $display("test bypass and reset done");
  endtask : t_bypass_reset

  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'h1;
    repeat (3) @(posedge clock);
    t_reset();
    t_ops();
    t_sample_extest();
    t_bypass_reset();
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
